// file: inc/otp_config_map.vh
`ifndef OTP_CONFIG_MAP_VH
`define OTP_CONFIG_MAP_VH
// ----------------------------------------
// memory geometry
// ----------------------------------------
`define OTP_ADDR_W 9
`define OTP_DEPTH 512
`define OTP_LAST_ADDR 9'h1FF
// ----------------------------------------
// offsets
// ----------------------------------------
`define OFS_FACTORY_CFG0 9'h000
`define OFS_FACTORY_CFG1 9'h001
`define OFS_FACTORY_CFG2 9'h002
`define OFS_CLK_PWR_CFG 9'h003
`define OFS_VALID_FLAGS 9'h004
`define OFS_LINE_FMT0 9'h005
`define OFS_MAKER_ID_LO 9'h00C
`define OFS_MAKER_ID_HI 9'h00D
`define OFS_PART_ID_LO 9'h00E
`define OFS_PART_ID_HI 9'h00F
`define OFS_PWR_ATTR 9'h010
`define OFS_MAX_CURRENT 9'h011
`define OFS_MAKER_TEXT 9'h012
`define OFS_PART_TEXT 9'h022
`define OFS_SERIAL_TEXT 9'h032
`define OFS_CUSTOM_VALUES 9'h042
`define LINE_FMT_BYTES 7
`define TEXT_BYTES 16
// ----------------------------------------
// field positions
// ----------------------------------------
`define BIT_LOWPOWER_POL 1
`define CLKDIV_MSB 2
`define CLKDIV_LSB 0
`define BIT_BUS_SENSE_EN 3
`define BIT_VALID_DESC 0
`define BIT_VALID_STRINGS 1
`define BIT_VALID_LINE 2
`define BIT_ATTR_WAKEUP 5
`define BIT_ATTR_SELF_PWR 6
// ----------------------------------------
// clock divider codes
// ----------------------------------------
`define CORE_CLOCK_FULL_RATE 3'h0
`define CORE_CLOCK_HALF_RATE 3'h1
`define CORE_CLOCK_QUARTER_RATE 3'h2
`define CORE_CLOCK_EIGHTH_RATE 3'h3
`define DIV_CNT_W 3
`define DIV_MASK_1 3'h0
`define DIV_MASK_2 3'h1
`define DIV_MASK_4 3'h3
`define DIV_MASK_8 3'h7
// ----------------------------------------
// erased value and defaults
// ----------------------------------------
`define OTP_ERASED 8'h00
`define BUILTIN_VENDOR_ID 16'h1234
`define BUILTIN_PRODUCT_ID 16'h5678
`define BUILTIN_ATTR 8'h80
`define BUILTIN_MAX_CURRENT 8'h32
`define BUILTIN_LINE_CODING 56'h08_00_00_00_00_25_80
`define ATTR_FIXED_ONE 8'h80
`endif

// file: verilog/otp_power_up_configuration.v
`timescale 1ns/100ps
`include "otp_config_map.vh"
module otp_power_up_configuration (
    input wire clk,
    input wire srst,
    input wire hostReq,
    input wire hostWrite,
    input wire [`OTP_ADDR_W-1:0] hostAddr,
    input wire [7:0] hostWdata,
    output reg [7:0] hostRdata,
    output reg hostAck,
    input wire lowPowerState,
    input wire busPowerPin,
    input wire [7:0] stringIndex,
    output reg [7:0] stringByte,
    output reg configLoaded,
    output reg coreClockEnable,
    output reg lowPowerOut,
    output reg busPowerSenseEnable,
    output reg busPowerPresent,
    output reg [15:0] vendorId,
    output reg [15:0] productId,
    output reg [7:0] descAttributes,
    output reg [7:0] descMaxCurrent,
    output reg [55:0] lineCoding,
    output reg stringsOverride
);
    // ----------------------------------------
    // storage and load sequencer
    // ----------------------------------------
    localparam ST_LOAD = 1'b0;
    localparam ST_RUN = 1'b1;
    reg [7:0] otpMem [0:`OTP_DEPTH-1];
    reg state_r;
    reg [`OTP_ADDR_W-1:0] loadAddr_r;
    reg [7:0] cfg0_r, cfg3_r, valid_r, attr_r, maxCur_r;
    reg [7:0] vidLo_r, vidHi_r, pidLo_r, pidHi_r;
    reg [55:0] line_r;
    reg [`DIV_CNT_W-1:0] divCnt_r;
    reg [`DIV_CNT_W-1:0] divMask;
    reg busSync1_r, busSync2_r;
    wire [7:0] loadByte;
    wire hostWriteOk;
    integer k;

    function inRange;
        input [`OTP_ADDR_W-1:0] a;
        input [`OTP_ADDR_W-1:0] base;
        input [`OTP_ADDR_W-1:0] cnt;
        begin
            inRange = (a >= base) && (a < base + cnt);
        end
    endfunction

    assign loadByte = otpMem[loadAddr_r];
    assign hostWriteOk = hostReq && hostWrite && (state_r == ST_RUN);

    // ----------------------------------------
    // host access, write ORs bits like fused OTP
    // ----------------------------------------
    always @(posedge clk) begin
        if (hostWriteOk) begin
            otpMem[hostAddr] <= otpMem[hostAddr] | hostWdata;
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            hostAck <= 1'b0;
            hostRdata <= `OTP_ERASED;
        end else begin
            hostAck <= hostReq && (state_r == ST_RUN);
            if (hostReq && !hostWrite && state_r == ST_RUN) begin
                hostRdata <= otpMem[hostAddr];
            end
        end
    end

    // ----------------------------------------
    // power-up load of working settings
    // ----------------------------------------
    always @(posedge clk) begin
        if (srst) begin
            state_r <= ST_LOAD;
            loadAddr_r <= `OFS_FACTORY_CFG0;
            configLoaded <= 1'b0;
            cfg0_r <= `OTP_ERASED;
            cfg3_r <= `OTP_ERASED;
            valid_r <= `OTP_ERASED;
            attr_r <= `OTP_ERASED;
            maxCur_r <= `OTP_ERASED;
            vidLo_r <= `OTP_ERASED;
            vidHi_r <= `OTP_ERASED;
            pidLo_r <= `OTP_ERASED;
            pidHi_r <= `OTP_ERASED;
            line_r <= 56'h0;
        end else begin
            case (state_r)
                ST_LOAD: begin
                    case (loadAddr_r)
                        `OFS_FACTORY_CFG0: cfg0_r <= loadByte;
                        `OFS_CLK_PWR_CFG: cfg3_r <= loadByte;
                        `OFS_VALID_FLAGS: valid_r <= loadByte;
                        `OFS_MAKER_ID_LO: vidLo_r <= loadByte;
                        `OFS_MAKER_ID_HI: vidHi_r <= loadByte;
                        `OFS_PART_ID_LO: pidLo_r <= loadByte;
                        `OFS_PART_ID_HI: pidHi_r <= loadByte;
                        `OFS_PWR_ATTR: attr_r <= loadByte;
                        `OFS_MAX_CURRENT: maxCur_r <= loadByte;
                        default: begin
                        end
                    endcase
                    if (inRange(loadAddr_r, `OFS_LINE_FMT0, `LINE_FMT_BYTES)) begin
                        // byte 0 of the line coding is the lowest byte of the baud rate
                        line_r <= {loadByte, line_r[55:8]};
                    end
                    if (loadAddr_r == `OFS_MAX_CURRENT) begin
                        state_r <= ST_RUN;
                        configLoaded <= 1'b1;
                    end else begin
                        loadAddr_r <= loadAddr_r + 9'h001;
                    end
                end
                ST_RUN: begin
                end
                default: state_r <= ST_LOAD;
            endcase
        end
    end

    // ----------------------------------------
    // core clock divider enable
    // ----------------------------------------
    always @* begin
        case (cfg3_r[`CLKDIV_MSB:`CLKDIV_LSB])
            `CORE_CLOCK_FULL_RATE: divMask = `DIV_MASK_1;
            `CORE_CLOCK_HALF_RATE: divMask = `DIV_MASK_2;
            `CORE_CLOCK_QUARTER_RATE: divMask = `DIV_MASK_4;
            `CORE_CLOCK_EIGHTH_RATE: divMask = `DIV_MASK_8;
            default: divMask = `DIV_MASK_1;
        endcase
    end

    always @(posedge clk) begin
        if (srst || !configLoaded) begin
            divCnt_r <= 3'h0;
            coreClockEnable <= 1'b0;
        end else begin
            divCnt_r <= (divCnt_r & divMask) == divMask ? 3'h0 : divCnt_r + 3'h1;
            coreClockEnable <= (divCnt_r & divMask) == divMask;
        end
    end

    // ----------------------------------------
    // pins and bus-power sense
    // ----------------------------------------
    always @(posedge clk) begin
        if (srst) begin
            busSync1_r <= 1'b0;
            busSync2_r <= 1'b0;
            lowPowerOut <= 1'b0;
            busPowerSenseEnable <= 1'b0;
            busPowerPresent <= 1'b0;
        end else begin
            busSync1_r <= busPowerPin;
            busSync2_r <= busSync1_r;
            lowPowerOut <= ~(lowPowerState ^ cfg0_r[`BIT_LOWPOWER_POL]);
            busPowerSenseEnable <= cfg3_r[`BIT_BUS_SENSE_EN];
            busPowerPresent <= cfg3_r[`BIT_BUS_SENSE_EN] ? busSync2_r : 1'b1;
        end
    end

    // ----------------------------------------
    // descriptor overrides
    // ----------------------------------------
    always @(posedge clk) begin
        if (srst) begin
            vendorId <= `BUILTIN_VENDOR_ID;
            productId <= `BUILTIN_PRODUCT_ID;
            descAttributes <= `BUILTIN_ATTR;
            descMaxCurrent <= `BUILTIN_MAX_CURRENT;
            lineCoding <= `BUILTIN_LINE_CODING;
            stringsOverride <= 1'b0;
            stringByte <= `OTP_ERASED;
        end else begin
            if (valid_r[`BIT_VALID_DESC]) begin
                vendorId <= {vidHi_r, vidLo_r};
                productId <= {pidHi_r, pidLo_r};
                descAttributes <= `ATTR_FIXED_ONE | (attr_r & 8'h60);
                descMaxCurrent <= maxCur_r;
            end else begin
                vendorId <= `BUILTIN_VENDOR_ID;
                productId <= `BUILTIN_PRODUCT_ID;
                descAttributes <= `BUILTIN_ATTR;
                descMaxCurrent <= `BUILTIN_MAX_CURRENT;
            end
            lineCoding <= valid_r[`BIT_VALID_LINE] ? line_r : `BUILTIN_LINE_CODING;
            stringsOverride <= valid_r[`BIT_VALID_STRINGS];
            if (valid_r[`BIT_VALID_STRINGS] && stringIndex < 8'h30) begin
                stringByte <= otpMem[`OFS_MAKER_TEXT + {1'b0, stringIndex}];
            end else begin
                stringByte <= `OTP_ERASED;
            end
        end
    end
endmodule

// file: testbench/otp_power_up_configuration_properties.sv
`timescale 1ns/100ps
module otp_power_up_configuration_chk (
    input wire clk,
    input wire srst,
    input wire hostReq,
    input wire hostAck,
    input wire configLoaded,
    input wire coreClockEnable,
    input wire lowPowerState,
    input wire lowPowerOut,
    input wire busPowerSenseEnable,
    input wire busPowerPresent,
    input wire [7:0] stringIndex,
    input wire [7:0] stringByte,
    input wire stringsOverride,
    input wire [7:0] descAttributes
);
// ----
// port relations
// ----
default clocking @(posedge clk); endclocking
default disable iff (srst);
a_ack_after_req: assert property (hostReq && configLoaded |=> hostAck)
    else $error("request not acknowledged");
a_no_load_ack: assert property (!configLoaded |=> !hostAck)
    else $error("ack during load");
a_load_bound: assert property ($fell(srst) |-> !configLoaded ##[8:24] configLoaded)
    else $error("load not finished in time");
a_div_pulse: assert property (configLoaded && coreClockEnable |-> ##[1:8] coreClockEnable)
    else $error("core clock pulse gap too long");
a_pol_stable: assert property ($past(configLoaded, 2) && $past(configLoaded) && configLoaded
    |-> (lowPowerOut ^ $past(lowPowerState)) == ($past(lowPowerOut) ^ $past(lowPowerState, 2)))
    else $error("low-power polarity not steady");
a_sense_off: assert property ($past(configLoaded) && !$past(busPowerSenseEnable)
    && !busPowerSenseEnable |-> busPowerPresent) else $error("present low with sense off");
a_str_gate: assert property ($past(configLoaded) && !$past(stringsOverride)
    |-> stringByte == 8'h00) else $error("text byte without override");
a_str_range: assert property (configLoaded && stringIndex > 8'h2F |=> stringByte == 8'h00)
    else $error("text byte past end");
a_attr_form: assert property (configLoaded |-> descAttributes[7] && descAttributes[4:0] == 5'h00)
    else $error("attribute reserved bits");
cover property (hostReq && configLoaded);
cover property ($rose(configLoaded));
cover property (stringsOverride && stringByte != 8'h00);
endmodule
bind otp_power_up_configuration otp_power_up_configuration_chk i_chk (.*);

// file: testbench/usb_host_model.sv
`timescale 1ns/100ps
module usb_host_model (
    input wire clk,
    input wire hostAck,
    input wire [7:0] hostRdata,
    output reg hostReq,
    output reg hostWrite,
    output reg [8:0] hostAddr,
    output reg [7:0] hostWdata
);
// ----
// one access, request high one cycle; no baud traffic so any divider is safe
// ----
initial begin
    hostReq = 1'b0;
    hostWrite = 1'b0;
    hostAddr = 9'h000;
    hostWdata = 8'h00;
end
task access(input w, input [8:0] a, input [7:0] d, output [7:0] rd, output ak);
    begin
        @(negedge clk);
        hostReq = 1'b1;
        hostWrite = w;
        hostAddr = a;
        hostWdata = (a == 9'h001 || a == 9'h002) ? 8'h00 : (a == 9'h000) ? (d & 8'h02) : d;
        if (a == 9'h003) hostWdata = d & 8'h0B;
        @(negedge clk);
        hostReq = 1'b0;
        rd = hostRdata;
        ak = hostAck;
        hostAddr = ~hostAddr;
        hostWdata = ~hostWdata;
    end
endtask
endmodule

// file: testbench/otp_power_up_configuration_tb_top.sv
`timescale 1ns/100ps
`include "otp_config_map.vh"
module otp_power_up_configuration_tb_top;
// ----
// bench
// ----
reg clk = 1'b0, srst = 1'b1, lowPowerState = 1'b0, busPowerPin = 1'b1;
reg [7:0] stringIndex = 8'h00;
wire hostReq, hostWrite, hostAck, configLoaded, coreClockEnable, lowPowerOut;
wire busPowerSenseEnable, busPowerPresent, stringsOverride;
wire [8:0] hostAddr;
wire [7:0] hostWdata, hostRdata, stringByte, descAttributes, descMaxCurrent;
wire [15:0] vendorId, productId;
wire [55:0] lineCoding;
integer err_count = 0, n_tests = 0, i, j;
localparam [55:0] LC = 56'h08_00_00_00_01_C2_00;
localparam [31:0] IDS = 32'hCAFE_BEEF;
always #5 clk = ~clk;
usb_host_model i_host (.clk(clk), .hostAck(hostAck), .hostRdata(hostRdata), .hostReq(hostReq),
    .hostWrite(hostWrite), .hostAddr(hostAddr), .hostWdata(hostWdata));
otp_power_up_configuration i_dut (.clk(clk), .srst(srst), .hostReq(hostReq),
    .hostWrite(hostWrite), .hostAddr(hostAddr), .hostWdata(hostWdata), .hostRdata(hostRdata),
    .hostAck(hostAck), .lowPowerState(lowPowerState), .busPowerPin(busPowerPin),
    .stringIndex(stringIndex), .stringByte(stringByte), .configLoaded(configLoaded),
    .coreClockEnable(coreClockEnable), .lowPowerOut(lowPowerOut),
    .busPowerSenseEnable(busPowerSenseEnable), .busPowerPresent(busPowerPresent),
    .vendorId(vendorId), .productId(productId), .descAttributes(descAttributes),
    .descMaxCurrent(descMaxCurrent), .lineCoding(lineCoding), .stringsOverride(stringsOverride));
task chk(input string nm, input [63:0] e, input [63:0] g);
    begin
        n_tests = n_tests + 1;
        if (g !== e) begin
            err_count = err_count + 1;
            $display("MISMATCH %s exp %0h got %0h", nm, e, g);
        end
    end
endtask
task summarize;
    begin
        if (err_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    end
endtask
task prog(input [8:0] a, input [7:0] d);
    reg [7:0] r;
    reg k;
    begin
        i_host.access(1'b1, a, d, r, k);
        chk("progAck", 1, k);
        i_host.access(1'b0, a, 8'h00, r, k);
        chk("readBack", d, r);
    end
endtask
task do_reset;
    integer n;
    reg [7:0] r;
    reg k;
    begin
        srst = 1'b1;
        repeat (12) @(negedge clk);
        srst = 1'b0;
        i_host.access(1'b0, 9'h004, 8'h00, r, k);
        chk("loadAck", 0, k);
        n = 2;
        while (configLoaded !== 1'b1 && n < 40) begin
            @(negedge clk);
            n = n + 1;
        end
        chk("loadTime", 1, n >= 16 && n <= 22);
        repeat (2) @(negedge clk);
    end
endtask
task check_cfg(input p, input [7:0] v, input s, input integer per);
    integer n;
    begin
        do_reset;
        lowPowerState = 1'b1;
        repeat (2) @(negedge clk);
        chk("lowPowerOut", p, lowPowerOut);
        lowPowerState = 1'b0;
        busPowerPin = 1'b0;
        repeat (4) @(negedge clk);
        chk("lowPowerOut", !p, lowPowerOut);
        chk("present", !s, busPowerPresent);
        chk("vendorId", v[0] ? IDS[15:0] : `BUILTIN_VENDOR_ID, vendorId);
        chk("productId", v[0] ? IDS[31:16] : `BUILTIN_PRODUCT_ID, productId);
        chk("attr", v[0] ? 8'hE0 : `BUILTIN_ATTR, descAttributes);
        chk("maxCur", v[0] ? 8'h64 : `BUILTIN_MAX_CURRENT, descMaxCurrent);
        chk("lineCoding", v[2] ? LC : `BUILTIN_LINE_CODING, lineCoding);
        stringIndex = 8'h00;
        repeat (2) @(negedge clk);
        chk("text0", v[1] ? 8'h41 : 8'h00, stringByte);
        stringIndex = 8'h30;
        repeat (2) @(negedge clk);
        chk("text48", 0, stringByte);
        busPowerPin = 1'b1;
        n = 0;
        while (coreClockEnable !== 1'b1 && n < 20) begin
            @(negedge clk);
            n = n + 1;
        end
        n = 0;
        do begin
            @(negedge clk);
            n = n + 1;
        end while (coreClockEnable !== 1'b1 && n < 20);
        chk("period", per, n);
    end
endtask
initial begin
    // the array is nonvolatile and never reset: start from an erased part
    for (j = 0; j < 512; j = j + 1) i_dut.otpMem[j] = 8'h00;
end
initial begin
    #200000;
    err_count = err_count + 1;
    summarize;
end
initial begin
    check_cfg(1'b0, 8'h00, 1'b0, 1);
    prog(9'h000, 8'h02);
    prog(9'h003, 8'h09);
    prog(9'h004, 8'h07);
    for (i = 0; i < 7; i = i + 1) prog(i[8:0] + 9'h005, LC[8*i +: 8]);
    for (i = 0; i < 4; i = i + 1) prog(i[8:0] + 9'h00C, IDS[8*i +: 8]);
    prog(9'h010, 8'h60);
    prog(9'h011, 8'h64);
    prog(9'h012, 8'h41);
    check_cfg(1'b1, 8'h07, 1'b1, 2);
    prog(9'h003, 8'h0B);
    check_cfg(1'b1, 8'h07, 1'b1, 8);
    prog(9'h003, 8'h0B);
    check_cfg(1'b1, 8'h07, 1'b1, 8);
    summarize;
end
endmodule
